// File: design/ctsi_top.sv
// Transmit scheduling, buffer condition codes and interrupt code logic.
// Assumes a protocol engine that sends the offered buffer and reports
// frame start, CRC start, success and failure as one-cycle pulses.
`timescale 1ns/1ps
module ctsi_top
  import ctsi_pkg::*;
#(
  parameter int NBUF = CTSI_NBUF,
  parameter int ERR_W = CTSI_ERR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [CTSI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CTSI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine transmit side
  output logic tx_req,
  output logic [CTSI_IDX_W-1:0] tx_buf_idx,
  input wire logic tx_start,
  input wire logic crc_start,
  input wire logic tx_done,
  input wire logic tx_remote_sent,
  input wire logic tx_fail,
  // Protocol engine receive side
  input wire logic rx_store,
  input wire logic [CTSI_IDX_W-1:0] rx_store_idx,
  input wire logic rx_remote,
  input wire logic [CTSI_IDX_W-1:0] rx_remote_idx,
  // Bus errors
  input wire logic bus_error,
  input wire logic [ERR_W-1:0] bus_error_bits,
  // Interrupt line
  output logic irq
);
  logic [3:0] st_r [NBUF];
  logic [3:0] pri_r [NBUF];
  logic [15:0] pend_r, ien_r, en_pend, clr_vec, set_vec;
  logic [ERR_W-1:0] ediag_r;
  logic sel_valid_r, cur_active_r, crc_seen_r;
  logic [CTSI_IDX_W-1:0] sel_idx_r, cur_idx_r, best_idx;
  logic [7:0] best_rank, sel_rank;
  logic best_valid, window, sched_ok, do_mark, cancel;
  logic [NBUF-1:0] req;
  logic aw_hold_r, w_hold_r, wr_go;
  logic [CTSI_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, rd_data;
  logic [3:0] w_strb_r;
  logic wr_buf, wr_hit, rd_hit;
  logic [CTSI_IDX_W-1:0] wr_idx;
  logic irq_flag;
  logic [3:0] irq_code;

  // AXI4-Lite write path: address and data are taken in either order.
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r;
  assign wr_idx = aw_addr_r[5:2];
  assign wr_buf = wr_go && w_strb_r[0] && (aw_addr_r <= OFF_BUF_END)
                  && (32'(wr_idx) < NBUF);
  assign wr_hit = (aw_addr_r <= OFF_BUF_END && 32'(wr_idx) < NBUF)
                  || aw_addr_r == OFF_IEN || aw_addr_r == OFF_ICLR
                  || aw_addr_r == OFF_EDIAG || aw_addr_r == OFF_IPND
                  || aw_addr_r == OFF_STPND || aw_addr_r == OFF_SCHED;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[CTSI_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path: one cycle from address to data.
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    logic [CTSI_IDX_W-1:0] ri;
    ri = s_axi_araddr[5:2];
    rd_data = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr <= OFF_BUF_END && 32'(ri) < NBUF)
      rd_data = {24'h0, pri_r[ri], st_r[ri]};
    else if (s_axi_araddr[7:2] == OFF_IPND[7:2])
      rd_data = {16'h0, pend_r};
    else if (s_axi_araddr[7:2] == OFF_IEN[7:2])
      rd_data = {16'h0, ien_r};
    else if (s_axi_araddr[7:2] == OFF_STPND[7:2])
      rd_data = {27'h0, irq_flag, irq_code};
    else if (s_axi_araddr[7:2] == OFF_EDIAG[7:2])
      rd_data = 32'(ediag_r);
    else if (s_axi_araddr[7:2] == OFF_SCHED[7:2])
      rd_data = {22'h0, cur_active_r, cur_idx_r, sel_valid_r, sel_idx_r};
    else if (s_axi_araddr[7:2] != OFF_ICLR[7:2])
      rd_hit = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Requesting buffers and the best rank among them.
  always_comb begin
    logic [7:0] rk;
    rk = 8'h00;
    best_valid = 1'b0;
    best_idx = '0;
    best_rank = 8'hFF;
    for (int i = 0; i < NBUF; i++) begin
      req[i] = st_r[i] == ST_TX_SINGLE || st_r[i] == ST_TX_THEN_AWAIT;
      rk = {pri_r[i], CTSI_IDX_W'(i)};
      // Strict compare in rising index order keeps the lower index on a tie.
      if (req[i] && (!best_valid || rk < best_rank)) begin
        best_valid = 1'b1;
        best_idx = CTSI_IDX_W'(i);
        best_rank = rk;
      end
    end
  end

  assign sel_rank = {pri_r[sel_idx_r], sel_idx_r};
  assign window = !cur_active_r || crc_seen_r;
  assign cancel = wr_buf && sel_valid_r && wr_idx == sel_idx_r
                  && w_data_r[3:0] == ST_TX_IDLE;
  assign sched_ok = window && !tx_start && !tx_done && !tx_fail && !cancel;
  assign do_mark = sched_ok && best_valid
                   && (!sel_valid_r || best_rank < sel_rank);
  // The next frame is offered as soon as it is chosen, so the engine can
  // arbitrate again straight after the previous frame ends.
  assign tx_req = sel_valid_r;
  assign tx_buf_idx = sel_idx_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_valid_r <= 1'b0;
      sel_idx_r <= '0;
      cur_active_r <= 1'b0;
      cur_idx_r <= '0;
      crc_seen_r <= 1'b0;
    end else begin
      if (tx_start && sel_valid_r) begin
        cur_active_r <= 1'b1;
        cur_idx_r <= sel_idx_r;
        sel_valid_r <= 1'b0;
        crc_seen_r <= 1'b0;
      end else if (tx_done || tx_fail) begin
        cur_active_r <= 1'b0;
        crc_seen_r <= 1'b0;
      end else if (crc_start) begin
        crc_seen_r <= 1'b1;
      end
      if (cancel) begin
        sel_valid_r <= 1'b0;
      end else if (do_mark) begin
        sel_valid_r <= 1'b1;
        sel_idx_r <= best_idx;
      end
    end
  end

  // Buffer condition codes and the events they raise.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NBUF; i++) begin
        st_r[i] <= ST_RX_IDLE;
        pri_r[i] <= PRI_RST;
      end
    end else begin
      for (int i = 0; i < NBUF; i++) begin
        if (tx_done && cur_active_r && 32'(cur_idx_r) == i) begin
          if (st_r[i] == (ST_TX_THEN_AWAIT | 4'h1))
            st_r[i] <= ST_AWAIT_REMOTE;
          else
            st_r[i] <= tx_remote_sent ? ST_RX_ARMED : ST_TX_IDLE;
        end else if (tx_fail && cur_active_r && 32'(cur_idx_r) == i) begin
          st_r[i][ST_BUSY_POS] <= 1'b0;
        end else if (do_mark && 32'(best_idx) == i) begin
          st_r[i][ST_BUSY_POS] <= 1'b1;
        end else if (do_mark && sel_valid_r && 32'(sel_idx_r) == i) begin
          st_r[i][ST_BUSY_POS] <= 1'b0;
        end else if (cancel && 32'(wr_idx) == i) begin
          st_r[i] <= ST_TX_IDLE;
        end else if (rx_remote && 32'(rx_remote_idx) == i
                     && st_r[i] == ST_AWAIT_REMOTE) begin
          st_r[i] <= ST_TX_THEN_AWAIT;
        end else if (rx_store && 32'(rx_store_idx) == i
                     && !st_r[i][ST_TX_POS] && st_r[i] != ST_RX_IDLE) begin
          st_r[i] <= st_r[i] == ST_RX_ARMED ? ST_RX_HOLD : ST_RX_LOST;
        end else if (wr_buf && 32'(wr_idx) == i
                     && !st_r[i][ST_BUSY_POS]) begin
          // The busy bit is never written; busy buffers keep their word, except a picked unstarted one, which a write of idle cancels.
          st_r[i] <= {w_data_r[3:1], 1'b0};
          pri_r[i] <= w_data_r[7:4];
        end
      end
    end
  end

  // Interrupt sources: set wins over a clear in the same cycle.
  always_comb begin
    set_vec = '0;
    for (int i = 0; i < NBUF; i++) begin
      set_vec[i] = (tx_done && cur_active_r && 32'(cur_idx_r) == i)
        || (rx_remote && 32'(rx_remote_idx) == i
            && st_r[i] == ST_AWAIT_REMOTE)
        || (rx_store && 32'(rx_store_idx) == i && !st_r[i][ST_TX_POS]
            && st_r[i] != ST_RX_IDLE);
    end
    set_vec[CTSI_ERR_BIT] = bus_error;
  end
  assign clr_vec = (wr_go && aw_addr_r == OFF_ICLR)
                   ? (w_data_r[15:0] & {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}})
                   : 16'h0000;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_r <= '0;
      ien_r <= IEN_RST;
      ediag_r <= '0;
    end else begin
      pend_r <= (pend_r & ~clr_vec) | set_vec;
      if (wr_go && aw_addr_r == OFF_IEN) begin
        if (w_strb_r[0]) ien_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1]) ien_r[15:8] <= w_data_r[15:8];
      end
      ediag_r <= (ediag_r & ~((wr_go && aw_addr_r == OFF_EDIAG)
                 ? w_data_r[ERR_W-1:0] : '0))
                 | (bus_error ? bus_error_bits : '0);
    end
  end

  // Code of the top enabled request, recomputed every cycle.
  assign en_pend = pend_r & ien_r;
  always_comb begin
    irq_flag = 1'b0;
    irq_code = 4'h0;
    if (en_pend[CTSI_ERR_BIT]) begin
      irq_flag = 1'b1;
    end else begin
      for (int i = NBUF - 1; i >= 0; i--) begin
        if (en_pend[i]) begin
          irq_flag = 1'b1;
          irq_code = 4'(i + 1);
        end
      end
    end
  end
  assign irq = |en_pend;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_irq_merge: assert property (|(set_vec & ien_r)
    && !(wr_go && aw_addr_r == OFF_IEN) |=> irq)
    else $error("enabled interrupt event did not raise irq");
  a_code_error: assert property (en_pend[CTSI_ERR_BIT] |->
    irq_flag && irq_code == 4'h0)
    else $error("error request not coded as 0000");
  a_code_buffer: assert property ((irq_flag && irq_code != 4'h0) |->
    en_pend[irq_code - 4'h1] && !en_pend[CTSI_ERR_BIT])
    else $error("interrupt code names no enabled buffer");
  a_clear_only: assert property (
    !(|($past(pend_r) & ~pend_r & ~$past(clr_vec))))
    else $error("pending flag dropped without a clear");
  a_error_flag: assert property (bus_error |=>
    pend_r[CTSI_ERR_BIT])
    else $error("bus error did not set its pending flag");
  a_done_idle: assert property ((tx_done && cur_active_r && !tx_remote_sent
    && st_r[cur_idx_r] == (ST_TX_SINGLE | 4'h1)) |=>
    st_r[$past(cur_idx_r)] == ST_TX_IDLE && pend_r[$past(cur_idx_r)])
    else $error("single data send did not return to idle");
  a_resend_await: assert property ((tx_done && cur_active_r
    && st_r[cur_idx_r] == (ST_TX_THEN_AWAIT | 4'h1)) |=>
    st_r[$past(cur_idx_r)] == ST_AWAIT_REMOTE)
    else $error("send then await did not move to await");
  a_remote_trig: assert property ((rx_remote
    && st_r[rx_remote_idx] == ST_AWAIT_REMOTE && !do_mark) |=>
    st_r[$past(rx_remote_idx)] == ST_TX_THEN_AWAIT
    && pend_r[$past(rx_remote_idx)])
    else $error("remote frame did not trigger a resend");
  a_pick_best: assert property (do_mark |=> sel_valid_r
    && sel_idx_r == $past(best_idx)
    && st_r[sel_idx_r][ST_BUSY_POS])
    else $error("scheduler did not take the smallest rank");
  a_preempt_undo: assert property ((do_mark && sel_valid_r
    && sel_idx_r != best_idx) |=>
    !st_r[$past(sel_idx_r)][ST_BUSY_POS])
    else $error("preempted buffer kept its busy bit");

  c_send_done: cover property (tx_done && cur_active_r);
  c_remote_hit: cover property (rx_remote
    && st_r[rx_remote_idx] == ST_AWAIT_REMOTE);
  c_preempt: cover property (do_mark && sel_valid_r);
  c_clear_set: cover property (|(clr_vec & set_vec));
endmodule // ctsi_top

// File: design/ctsi_pkg.sv
// Constants for the CAN transmit scheduler and interrupt code block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package ctsi_pkg;
  localparam int CTSI_NBUF = 15;
  localparam int CTSI_IDX_W = 4;
  localparam int CTSI_ERR_W = 8;
  localparam int CTSI_ADDR_W = 8;
  localparam int CTSI_ERR_BIT = 15;
  // Buffer condition codes; bit 0 is the busy bit, bit 3 the transmit bit.
  localparam logic [3:0] ST_RX_IDLE = 4'h0;
  localparam logic [3:0] ST_RX_ARMED = 4'h2;
  localparam logic [3:0] ST_RX_HOLD = 4'h4;
  localparam logic [3:0] ST_RX_LOST = 4'h6;
  localparam logic [3:0] ST_TX_IDLE = 4'h8;
  localparam logic [3:0] ST_AWAIT_REMOTE = 4'hA;
  localparam logic [3:0] ST_TX_SINGLE = 4'hC;
  localparam logic [3:0] ST_TX_THEN_AWAIT = 4'hE;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_TX_POS = 3;
  // Register byte offsets.
  localparam logic [7:0] OFF_BUF_BASE = 8'h00;
  localparam logic [7:0] OFF_BUF_END = 8'h3C;
  localparam logic [7:0] OFF_IPND = 8'h40;
  localparam logic [7:0] OFF_IEN = 8'h44;
  localparam logic [7:0] OFF_ICLR = 8'h48;
  localparam logic [7:0] OFF_STPND = 8'h4C;
  localparam logic [7:0] OFF_EDIAG = 8'h50;
  localparam logic [7:0] OFF_SCHED = 8'h54;
  localparam int STPND_FLAG_POS = 4;
  localparam logic [15:0] IEN_RST = 16'h0000;
  localparam logic [3:0] PRI_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: verification/ctsi_engine_model.sv
// Behavioural protocol engine that sends whatever the scheduler offers.
// Assumes the scheduler holds tx_req until it sees tx_start.
`timescale 1ns/1ps
module ctsi_engine_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Scheduler side
  input wire logic tx_req,
  output logic tx_start,
  output logic crc_start,
  output logic tx_done,
  output logic tx_remote_sent,
  output logic tx_fail,
  // Bench control
  input wire logic hold,
  input wire logic remote_frame,
  input wire logic fail_en
);
  logic busy_r;
  logic [3:0] cnt_r;
  always_ff @(posedge mclk) begin
    tx_start <= 1'b0;
    crc_start <= 1'b0;
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
    tx_remote_sent <= 1'b0;
    cnt_r <= cnt_r + 4'h1;
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else if (!busy_r) begin
      // One idle cycle after an outcome keeps start apart from done.
      if (tx_req && !hold && !tx_done && !tx_fail) begin
        tx_start <= 1'b1;
        busy_r <= 1'b1;
        cnt_r <= 4'h0;
      end
    end else if (cnt_r == 4'h3) begin
      crc_start <= 1'b1;
    end else if (cnt_r == 4'h7) begin
      busy_r <= 1'b0;
      tx_fail <= fail_en;
      tx_done <= !fail_en;
      tx_remote_sent <= remote_frame & !fail_en;
    end
  end
endmodule // ctsi_engine_model

// File: verification/can_tx_sched_and_irq_code_tb_top.sv
// Self-checking bench for the transmit scheduler and interrupt code.
// Assumes the engine model beside it and AXI4-Lite register access.
`timescale 1ns/1ps
module can_tx_sched_and_irq_code_tb_top import ctsi_pkg::*;;
  logic mclk = 1'b0, sys_rst = 1'b1, hold = 1'b0, remote_frame = 1'b0;
  logic fail_en = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF, tx_buf_idx;
  logic [3:0] rx_store_idx = 4'h0, rx_remote_idx = 4'h0;
  logic rx_store = 1'b0, rx_remote = 1'b0, bus_error = 1'b0;
  logic [7:0] bus_error_bits = 8'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_req, tx_start, crc_start, tx_done;
  logic tx_remote_sent, tx_fail, irq;
  int bad_count = 0, checked = 0, done_cnt = 0, fail_cnt = 0, k;
  logic [3:0] started[$];
  logic [3:0] ord_idx[4] = '{4'h5, 4'h3, 4'h9, 4'h1};
  logic [3:0] ord_pri[4] = '{4'h2, 4'h2, 4'h1, 4'h3};
  logic [3:0] ord_exp[4] = '{4'h9, 4'h3, 4'h5, 4'h1};
  always #2 mclk = ~mclk;
  ctsi_top DUT (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_req, .tx_buf_idx,
    .tx_start, .crc_start, .tx_done, .tx_remote_sent, .tx_fail,
    .rx_store, .rx_store_idx, .rx_remote, .rx_remote_idx, .bus_error,
    .bus_error_bits, .irq);
  ctsi_engine_model ENG (.mclk, .sys_rst, .tx_req, .tx_start, .crc_start,
    .tx_done, .tx_remote_sent, .tx_fail, .hold, .remote_frame, .fail_en);
  always @(posedge mclk) begin
    if (tx_start === 1'b1) started.push_back(tx_buf_idx);
    if (tx_done === 1'b1) done_cnt++;
    if (tx_fail === 1'b1) fail_cnt++;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", RESP_OKAY, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic rb(input int i, input logic [7:0] e);
    rd(8'(4 * i));
    chk($sformatf("buffer %0d", i), {24'h0, e}, {24'h0, v[7:0]});
  endtask
  task automatic wait_done(input int n);
    k = 0;
    while (done_cnt < n && k < 500) begin
      @(posedge mclk);
      k++;
    end
    repeat (2) @(posedge mclk);
    chk("done count", 32'(n), 32'(done_cnt));
  endtask
  task automatic complete_run;
    $display("Counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(OFF_IPND, 32'h0);
    rc(OFF_STPND, 32'h0);
    rc(OFF_SCHED, 32'h0);
    rd(8'h58);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    wr(OFF_IEN, 32'h0000_FFFF);
    rc(OFF_IEN, 32'h0000_FFFF);
    // Stall the engine so that later, better requests preempt the pick.
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * ord_idx[i]), {24'h0, ord_pri[i], 4'h8});
      wr(8'(4 * ord_idx[i]), {24'h0, ord_pri[i], 4'hC});
    end
    rb(9, 8'h1D);
    rb(5, 8'h2C);
    hold <= 1'b0;
    wait_done(4);
    for (int i = 0; i < 4; i++) chk("order", ord_exp[i], started[i]);
    rb(9, 8'h18);
    rc(OFF_IPND, 32'h0000_022A);
    rc(OFF_STPND, 32'h12);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_IEN, 32'h0000_FFFD);
    rc(OFF_STPND, 32'h14);
    wr(OFF_ICLR, 32'h0000_0008);
    rc(OFF_STPND, 32'h16);
    wr(OFF_IPND, 32'h0);
    rc(OFF_IPND, 32'h0000_0222);
    wr(OFF_ICLR, 32'h0000_FFFF);
    rc(OFF_STPND, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    remote_frame <= 1'b1;
    wr(8'h08, 32'h0C);
    wait_done(5);
    remote_frame <= 1'b0;
    rb(2, 8'h02);
    rc(OFF_IPND, 32'h0000_0004);
    wr(OFF_ICLR, 32'h0000_0004);
    @(posedge mclk);
    rx_store <= 1'b1;
    rx_store_idx <= 4'h2;
    @(posedge mclk);
    rx_store <= 1'b0;
    repeat (2) @(posedge mclk);
    rb(2, 8'h04);
    rc(OFF_IPND, 32'h0000_0004);
    wr(8'h10, 32'h0A);
    repeat (20) @(posedge mclk);
    chk("starts", 32'd5, started.size());
    @(posedge mclk);
    rx_remote <= 1'b1;
    rx_remote_idx <= 4'h4;
    @(posedge mclk);
    rx_remote <= 1'b0;
    wait_done(6);
    rb(4, 8'h0A);
    rc(OFF_IPND, 32'h0000_0014);
    hold <= 1'b1;
    wr(8'h18, 32'h0E);
    repeat (4) @(posedge mclk);
    rb(6, 8'h0F);
    hold <= 1'b0;
    wait_done(7);
    rb(6, 8'h0A);
    // A picked but unstarted buffer can be withdrawn by writing idle.
    hold <= 1'b1;
    wr(8'h20, 32'h0C);
    wr(8'h20, 32'h5C);
    rb(8, 8'h0D);
    wr(8'h20, 32'h08);
    rb(8, 8'h08);
    chk("tx_req", 32'h0, {31'h0, tx_req});
    rc(OFF_SCHED, 32'h0000_00C8);
    hold <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("starts", 32'd7, started.size());
    // A lost frame must be offered again without software help.
    fail_en <= 1'b1;
    wr(8'h1C, 32'h0C);
    k = 0;
    while (fail_cnt < 1 && k < 500) begin
      @(posedge mclk);
      k++;
    end
    fail_en <= 1'b0;
    chk("fail count", 32'h1, 32'(fail_cnt));
    wait_done(8);
    chk("retry", 32'h7, {28'h0, started[started.size() - 2]});
    chk("retry", 32'h7, {28'h0, started[started.size() - 1]});
    wr(OFF_ICLR, 32'h0000_FFFF);
    @(posedge mclk);
    bus_error <= 1'b1;
    bus_error_bits <= 8'h5A;
    @(posedge mclk);
    bus_error <= 1'b0;
    repeat (2) @(posedge mclk);
    rc(OFF_IPND, 32'h0000_8000);
    rc(OFF_EDIAG, 32'h5A);
    wr(OFF_EDIAG, 32'h0A);
    rc(OFF_EDIAG, 32'h50);
    rc(OFF_STPND, 32'h10);
    wr(OFF_IEN, 32'h0000_7FFF);
    rc(OFF_STPND, 32'h0);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run;
  end
endmodule // can_tx_sched_and_irq_code_tb_top
